// ---- logic/slow_clock_control.sv ----
/*
 * Slow clock mode, miscellaneous control, external interrupt, reset pin,
 * general purpose ports A-C and analog shared port D control.
 * Assumes synchronous pin inputs, a 100 MHz oscillator on clk_sys and a
 * register master with one-cycle strobes, read data one cycle later.
 */
// Notes on behaviour
// - slow select inserts an extra divide by sixteen before the clock driver
// - slow mode bus clock is oscillator divided by thirty-two
// - normal bus clock is oscillator divided by two
// - every section runs from clk_sys; the divided bus clock is only an output
// - external or power-on reset clears slow select
// - entering stop clears slow select
// - misc register: slow bit 1, trigger bits 6 and 5, gate bit 4
// - two trigger bits choose one of four interrupt trigger options
// - gate bit enables or disables the external interrupt
// - trigger bits change only while the cpu interrupt mask is set
// - a new trigger option clears any pending external interrupt
// - low on the reset pin forces the start-up state
// - internal reset drives the reset pin low, open drain
// - 24 port lines have programmable direction, inputs after reset
// - port C line 2 can output the bus clock
// - port D is 8-bit input only, analog inputs when converter enabled
// - reset disables the converter, port D plain digital inputs
// - stop clears slow select so stop-exit delay counts at nominal speed
`include "slow_clock_regs.svh"

module slow_clock_control
	import slow_clock_pkg::*;
#(
	parameter int RST_DRIVE = `RST_DRIVE_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire reg_req_type reg_req,
	output logic [7:0]       rd_data,
	input  wire logic        cpu_i_mask,
	input  wire logic        stop_entry,
	input  wire logic        irq_pin_n,
	input  wire logic        irq_ack,
	output logic             irq_request,
	input  wire logic        watchdog_reset_source,
	input  wire logic        reset_pin_in,
	output logic             reset_pin_out,
	output logic             reset_pin_oe,
	input  wire logic [23:0] port_in,
	output logic [23:0]      port_out,
	output logic [23:0]      port_oe,
	input  wire logic [7:0]  analog_shared_input_port,
	output logic             analog_select,
	output logic             bus_clk,
	output logic             bus_tick,
	output logic             slow_active
);

	if (RST_DRIVE < 1 || RST_DRIVE > 255) begin : g_bad
		$error("slow_clock_control: RST_DRIVE out of range");
	end

	localparam logic [7:0] DRIVE_LOAD = 8'(RST_DRIVE);
	localparam logic [5:0] SLOW_LAG_MAX = 6'(2 * `SLOW_FACTOR + 2);
	localparam ctrl_state_type ST_RESET = '{
		misc: '{ext_irq_gate: 1'b1, default: 1'b0},
		irq_prev: 1'b1,
		default: '0
	};

	ctrl_state_type st;
	ctrl_state_type n;
	logic           soft_rst;
	logic           trig_event;
	logic [1:0]     trig_sel;
	logic [23:0]    port_view;
	logic [7:0]     misc_view;
	logic           div_clk;
	logic           div_tick;
	logic           div_slow;
	logic [5:0]     slow_lag_reg;
	logic [7:0]     drive_len_reg;

	// ---------------------------------------------------------------
	// bus clock divider, source of bus_clk and bus_tick; all sections run on clk_sys
	// ---------------------------------------------------------------
	bus_clock_divider #(
		.NORMAL_DIV  (`NORMAL_DIV),
		.SLOW_FACTOR (`SLOW_FACTOR)
	) u_div (
		.clk_sys     (clk_sys),
		.reset_n     (reset_n),
		.sync_clear  (soft_rst),
		.slow_req    (st.misc.slow_select),
		.bus_clk     (div_clk),
		.bus_tick    (div_tick),
		.slow_active (div_slow)
	);

	// ---------------------------------------------------------------
	// read views
	// ---------------------------------------------------------------
	always_comb begin
		soft_rst = !reset_pin_in; // pin low forces start-up state
		port_view = (st.dir & st.latch) | (~st.dir & port_in);
		misc_view = 8'h00;
		misc_view[`MISC_RISE_BIT] = st.misc.irq_rising_select;
		misc_view[`MISC_FALL_BIT] = st.misc.irq_falling_select;
		misc_view[`MISC_GATE_BIT] = st.misc.ext_irq_gate;
		misc_view[`MISC_SLOW_BIT] = st.misc.slow_select;
		trig_sel = {st.misc.irq_rising_select, st.misc.irq_falling_select};
	end

	// interrupt trigger: 00 low level or fall, 01 fall, 10 rise, 11 both
	always_comb begin
		unique case (trig_sel)
			2'b00: trig_event = !irq_pin_n;
			2'b01: trig_event = st.irq_prev && !irq_pin_n;
			2'b10: trig_event = !st.irq_prev && irq_pin_n;
			2'b11: trig_event = st.irq_prev != irq_pin_n;
		endcase
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		n = st;
		n.rd_data = 8'h00;
		n.irq_prev = irq_pin_n;

		// reset pin drive after an internal reset
		if (watchdog_reset_source)
			n.drive_cnt = DRIVE_LOAD;
		else if (st.drive_cnt != 8'h00)
			n.drive_cnt = st.drive_cnt - 8'h01;

		// register reads, data one cycle later
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				`OFS_PORT_A: n.rd_data = port_view[7:0];
				`OFS_PORT_B: n.rd_data = port_view[15:8];
				`OFS_PORT_C: n.rd_data = port_view[23:16];
				`OFS_PORT_D: n.rd_data = analog_shared_input_port;
				`OFS_DIR_A: n.rd_data = st.dir[7:0];
				`OFS_DIR_B: n.rd_data = st.dir[15:8];
				`OFS_DIR_C: n.rd_data = st.dir[23:16];
				`OFS_MISC: n.rd_data = misc_view;
				`OFS_CLK_CTRL: n.rd_data = {6'h00, st.adc_en, st.clk_out_en};
				`OFS_STATUS: n.rd_data = {4'h0, st.rst_oe, st.irq_pend, div_clk, div_slow};
				default: n.rd_data = 8'h00;
			endcase
		end

		// register writes
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				`OFS_PORT_A: n.latch[7:0] = reg_req.wdata;
				`OFS_PORT_B: n.latch[15:8] = reg_req.wdata;
				`OFS_PORT_C: n.latch[23:16] = reg_req.wdata;
				`OFS_DIR_A: n.dir[7:0] = reg_req.wdata;
				`OFS_DIR_B: n.dir[15:8] = reg_req.wdata;
				`OFS_DIR_C: n.dir[23:16] = reg_req.wdata;
				`OFS_MISC: begin
					n.misc.ext_irq_gate = reg_req.wdata[`MISC_GATE_BIT];
					n.misc.slow_select = reg_req.wdata[`MISC_SLOW_BIT];
					if (cpu_i_mask) begin
						n.misc.irq_rising_select = reg_req.wdata[`MISC_RISE_BIT];
						n.misc.irq_falling_select = reg_req.wdata[`MISC_FALL_BIT];
					end
				end
				`OFS_CLK_CTRL: begin
					n.clk_out_en = reg_req.wdata[`CLK_OUT_BIT];
					n.adc_en = reg_req.wdata[`ADC_EN_BIT];
				end
				default: ;
			endcase
		end

		// pending interrupt: a new event wins over ack and option change
		if (irq_ack)
			n.irq_pend = 1'b0;
		if ({n.misc.irq_rising_select, n.misc.irq_falling_select} != trig_sel)
			n.irq_pend = 1'b0;
		if (trig_event && st.misc.ext_irq_gate)
			n.irq_pend = 1'b1;

		// stop entry drops slow mode so the exit delay runs at full speed
		if (stop_entry)
			n.misc.slow_select = 1'b0;

		// pin reset: start-up state, the pin drive keeps running
		if (soft_rst) begin
			n = ST_RESET;
			n.drive_cnt = st.drive_cnt;
			if (watchdog_reset_source)
				n.drive_cnt = DRIVE_LOAD;
			else if (st.drive_cnt != 8'h00)
				n.drive_cnt = st.drive_cnt - 8'h01;
		end

		// registered pin outputs
		n.irq_req = n.irq_pend && n.misc.ext_irq_gate;
		n.rst_oe = n.drive_cnt != 8'h00;
		n.port_out = n.latch;
		n.port_oe = n.dir;
		if (n.clk_out_en) begin
			n.port_out[`PORT_C2_INDEX] = div_clk;
			n.port_oe[`PORT_C2_INDEX] = 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			st <= ST_RESET;
		else
			st <= n;
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign rd_data = st.rd_data;
	assign irq_request = st.irq_req;
	assign reset_pin_out = 1'b0; // open drain: only ever pulls low
	assign reset_pin_oe = st.rst_oe;
	assign port_out = st.port_out;
	assign port_oe = st.port_oe;
	assign analog_select = st.adc_en;
	assign bus_clk = div_clk;
	assign bus_tick = div_tick;
	assign slow_active = div_slow;

	// ---------------------------------------------------------------
	// check helpers
	// ---------------------------------------------------------------
	// wait of the slow bit for the divider, length of the pin drive;
	// counters stand in for long repetitions in the properties
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			slow_lag_reg <= 6'h00;
			drive_len_reg <= 8'h00;
		end else begin
			if (st.misc.slow_select && !div_slow)
				slow_lag_reg <= slow_lag_reg + 6'h01;
			else
				slow_lag_reg <= 6'h00;
			if (!reset_pin_oe)
				drive_len_reg <= 8'h00;
			else if (drive_len_reg != 8'hff)
				drive_len_reg <= drive_len_reg + 8'h01;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	chk_stop_clears_slow: assert property (@(posedge clk_sys) disable iff (!reset_n)
		stop_entry |=> !st.misc.slow_select)
		else $error("stop entry left slow select set");
	chk_mask_locks_trig: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!cpu_i_mask && reset_pin_in |=> $stable(trig_sel))
		else $error("trigger bits changed with mask clear");
	chk_option_clears_pend: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$changed(trig_sel) && !$past(trig_event) |-> !st.irq_pend)
		else $error("pending interrupt kept over option change");
	chk_wdog_drives_pin: assert property (@(posedge clk_sys) disable iff (!reset_n)
		watchdog_reset_source |=> reset_pin_oe)
		else $error("reset pin not driven after internal reset");
	chk_pin_drive_len: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$fell(reset_pin_oe) |-> drive_len_reg >= DRIVE_LOAD)
		else $error("reset pin drive shorter than the drive count");
	chk_pin_reset_state: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!reset_pin_in |=> port_oe == 24'h000000 && !analog_select && !st.misc.slow_select)
		else $error("pin reset did not restore start-up state");
	chk_gate_blocks_irq: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!st.misc.ext_irq_gate |-> !irq_request)
		else $error("interrupt request with gate off");
	chk_slow_follows_bit: assert property (@(posedge clk_sys) disable iff (!reset_n)
		slow_lag_reg < SLOW_LAG_MAX)
		else $error("slow mode not taken within a slow period");
	chk_clock_on_c2: assert property (@(posedge clk_sys) disable iff (!reset_n)
		n.clk_out_en && !soft_rst |=> port_oe[`PORT_C2_INDEX]
		&& port_out[`PORT_C2_INDEX] == $past(div_clk))
		else $error("port C line 2 not carrying the bus clock");
	chk_read_idle_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!$past(reg_req.rd) |-> rd_data == 8'h00)
		else $error("read data not zero outside a read answer");
	chk_misc_reads_back: assert property (@(posedge clk_sys) disable iff (!reset_n)
		reg_req.rd && reg_req.addr == `OFS_MISC && !soft_rst |=> rd_data == $past(misc_view))
		else $error("misc read did not return the misc bits");
	chk_ack_clears_pend: assert property (@(posedge clk_sys) disable iff (!reset_n)
		irq_ack && !trig_event |=> !st.irq_pend)
		else $error("acknowledge left the interrupt pending");
	chk_event_sets_pend: assert property (@(posedge clk_sys) disable iff (!reset_n)
		trig_event && st.misc.ext_irq_gate && !soft_rst |=> st.irq_pend)
		else $error("gated trigger event not made pending");
	chk_tick_on_rise: assert property (@(posedge clk_sys) disable iff (!reset_n)
		bus_tick |-> $rose(bus_clk))
		else $error("bus tick away from a bus clock rise");

endmodule : slow_clock_control

// ---- logic/slow_clock_regs.svh ----
/*
 * Register offsets, field positions, reset values and timing counts of the
 * slow clock and miscellaneous control block.
 * Assumes an 8-bit register port with byte offsets and a 100 MHz clk_sys.
 */
`ifndef SLOW_CLOCK_REGS_SVH
`define SLOW_CLOCK_REGS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OFS_PORT_A      8'h00
`define OFS_PORT_B      8'h01
`define OFS_PORT_C      8'h02
`define OFS_PORT_D      8'h03
`define OFS_DIR_A       8'h04
`define OFS_DIR_B       8'h05
`define OFS_DIR_C       8'h06
`define OFS_MISC        8'h0c
`define OFS_CLK_CTRL    8'h0e
`define OFS_STATUS      8'h0f

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define MISC_RISE_BIT   6
`define MISC_FALL_BIT   5
`define MISC_GATE_BIT   4
`define MISC_SLOW_BIT   1
`define MISC_RESET      8'h10
`define CLK_OUT_BIT     0
`define ADC_EN_BIT      1
`define PORT_C2_INDEX   18

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS   10
`define RST_DRIVE_NS    160
`define RST_DRIVE_CYC   ((`RST_DRIVE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NORMAL_DIV      2
`define SLOW_FACTOR     16

`endif

// ---- logic/slow_clock_pkg.sv ----
/*
 * Types of the slow clock and miscellaneous control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package slow_clock_pkg;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_type;

	typedef struct packed {
		logic irq_rising_select;
		logic irq_falling_select;
		logic ext_irq_gate;
		logic slow_select;
	} misc_type;

	// ---------------------------------------------------------------
	// state records
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [4:0] cnt;
		logic       clk_hi;
		logic       slow_on;
		logic       tick;
	} div_state_type;

	typedef struct packed {
		misc_type    misc;
		logic [23:0] latch;
		logic [23:0] dir;
		logic        clk_out_en;
		logic        adc_en;
		logic        irq_prev;
		logic        irq_pend;
		logic        irq_req;
		logic [7:0]  drive_cnt;
		logic        rst_oe;
		logic [7:0]  rd_data;
		logic [23:0] port_out;
		logic [23:0] port_oe;
	} ctrl_state_type;

endpackage : slow_clock_pkg

// ---- logic/bus_clock_divider.sv ----
/*
 * Bus clock divider: oscillator/2 normally, oscillator/32 in slow mode.
 * Assumes clk_sys is the oscillator and slow_req is a synchronous level.
 */
`include "slow_clock_regs.svh"

module bus_clock_divider
	import slow_clock_pkg::*;
#(
	parameter int NORMAL_DIV  = `NORMAL_DIV,
	parameter int SLOW_FACTOR = `SLOW_FACTOR
) (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	input  wire logic sync_clear,
	input  wire logic slow_req,
	output logic      bus_clk,
	output logic      bus_tick,
	output logic      slow_active
);

	if (NORMAL_DIV != 2 || SLOW_FACTOR < 2 || SLOW_FACTOR > 32) begin : g_bad
		$error("bus_clock_divider: unsupported division");
	end

	localparam logic [4:0] HALF_SLOW = 5'(SLOW_FACTOR - 1);
	localparam logic [5:0] SLOW_HALF_LEN = 6'(SLOW_FACTOR);

	div_state_type st;
	div_state_type n;
	logic [4:0]    half_m1;
	logic [5:0]    hi_run_reg;

	// ---------------------------------------------------------------
	// next state: mode taken at a rising bus edge; sync_clear drops to normal mode at once
	// ---------------------------------------------------------------
	always_comb begin
		n = st;
		n.tick = 1'b0;
		half_m1 = st.slow_on ? HALF_SLOW : 5'h00;
		if (st.cnt == half_m1) begin
			n.cnt = 5'h00;
			n.clk_hi = !st.clk_hi;
			if (!st.clk_hi) begin
				n.slow_on = slow_req; // full low phase done, switch safe
				n.tick = 1'b1;
			end
		end else begin
			n.cnt = st.cnt + 5'h01;
		end
		if (sync_clear)
			n = '0;
	end

	// state register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			st <= '0;
		else
			st <= n;
	end

	assign bus_clk = st.clk_hi;
	assign bus_tick = st.tick;
	assign slow_active = st.slow_on;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	// cycles the bus clock has stood high, saturating
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			hi_run_reg <= 6'h00;
		else if (!bus_clk)
			hi_run_reg <= 6'h00;
		else if (hi_run_reg != 6'h3f)
			hi_run_reg <= hi_run_reg + 6'h01;
	end

	chk_slow_high_len: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$fell(bus_clk) && slow_active |-> hi_run_reg == SLOW_HALF_LEN)
		else $error("slow bus high phase not 16 cycles");
	chk_normal_half: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$rose(bus_clk) && !slow_active |=> !bus_clk)
		else $error("normal bus high phase not 1 cycle");
	chk_switch_at_rise: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$changed(slow_active) && !$past(sync_clear) |-> $rose(bus_clk))
		else $error("bus clock mode changed mid period");

endmodule : bus_clock_divider

// ---- testbench/ext_source_model.sv ----
/*
 * Model of the external interrupt source and the reset pin wire.
 * Assumes the bench changes its commands right after clk_sys rising edges.
 */
module ext_source_model (
	input  wire logic clk_sys,
	input  wire logic irq_level_n,
	input  wire logic hold_reset,
	input  wire logic reset_pin_out,
	input  wire logic reset_pin_oe,
	output logic      irq_pin_n,
	output logic      reset_pin_in
);
	timeunit 1ns;
	timeprecision 1ns;

	// open drain wire with pull-up, low while either party pulls it
	assign reset_pin_in = !(hold_reset || (reset_pin_oe && !reset_pin_out));

	// pin level follows the commanded level one edge later, idle high
	initial irq_pin_n = 1'b1;
	always @(posedge clk_sys) begin
		irq_pin_n <= irq_level_n;
	end
endmodule : ext_source_model

// ---- testbench/slow_clock_and_misc_control_test.sv ----
/*
 * Self-checking bench of the slow clock and miscellaneous control block.
 * Assumes a 100 MHz clk_sys and the register offsets of the shared header.
 */
`include "slow_clock_regs.svh"

module slow_clock_and_misc_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	import slow_clock_pkg::*;

	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	localparam int DRV = 2;
	logic        clk_sys, reset_n, cpu_i_mask, stop_entry, irq_ack, wdog;
	logic        irq_level_n, hold_reset, irq_pin_n, reset_pin_in;
	logic        irq_request, reset_pin_out, reset_pin_oe, analog_select;
	logic        bus_clk, bus_tick, slow_active;
	reg_req_type req;
	logic [7:0]  rd_data, d, an_in;
	logic [23:0] port_in, port_out, port_oe;
	int          fails, total_checks;

	slow_clock_control #(.RST_DRIVE(DRV)) uut (
		.clk_sys(clk_sys), .reset_n(reset_n), .reg_req(req), .rd_data(rd_data),
		.cpu_i_mask(cpu_i_mask), .stop_entry(stop_entry), .irq_pin_n(irq_pin_n),
		.irq_ack(irq_ack), .irq_request(irq_request), .watchdog_reset_source(wdog),
		.reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
		.reset_pin_oe(reset_pin_oe), .port_in(port_in), .port_out(port_out),
		.port_oe(port_oe), .analog_shared_input_port(an_in),
		.analog_select(analog_select), .bus_clk(bus_clk), .bus_tick(bus_tick),
		.slow_active(slow_active)
	);

	ext_source_model pins (
		.clk_sys(clk_sys), .irq_level_n(irq_level_n), .hold_reset(hold_reset),
		.reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
		.irq_pin_n(irq_pin_n), .reset_pin_in(reset_pin_in)
	);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// free running oscillator
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop

	task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task step;
		@(posedge clk_sys);
		#1;
	endtask : step

	function logic probe(input int s);
		case (s)
			0: return slow_active;
			1: return bus_tick;
			2: return irq_request;
			default: return reset_pin_oe;
		endcase
	endfunction : probe

	// bounded wait, a timeout ends the run
	task await(input int s, input logic v, input int lim);
		for (int n = 0; n < lim; n++) begin
			if (probe(s) === v) return;
			step();
		end
		fails++;
		$display("MISMATCH wait %0d expected %b seen %b", s, v, probe(s));
		report_and_stop();
	endtask : await

	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge clk_sys);
		req <= '0;
		#1;
	endtask : wr

	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_sys);
		req <= '0;
		#1;
		v = rd_data;
	endtask : rd

	task period(input int hi, input int lo);
		int h, l;
		h = 0;
		l = 0;
		await(1, 1'b1, 80);
		while (bus_clk === 1'b1 && h < 40) begin
			h++;
			step();
		end
		while (bus_clk === 1'b0 && l < 40) begin
			l++;
			step();
		end
		check("bus_clk high", h, hi);
		check("bus_clk low", l, lo);
	endtask : period

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task t_reset;
		rd(`OFS_MISC, d);
		check("misc reset", d, 8'h10);
		check("port_oe reset", port_oe, 24'h000000);
		check("analog reset", analog_select, 1'b0);
		check("slow reset", slow_active, 1'b0);
		$display("reset test done");
	endtask : t_reset

	task t_clock;
		period(1, 1);
		wr(`OFS_MISC, 8'h12); // converter left off while slow
		await(0, 1'b1, 40);
		period(16, 16);
		rd(`OFS_MISC, d);
		check("misc slow", d, 8'h12);
		@(posedge clk_sys);
		stop_entry <= 1'b1;
		@(posedge clk_sys);
		stop_entry <= 1'b0;
		rd(`OFS_MISC, d);
		check("misc after stop", d, 8'h10);
		await(0, 1'b0, 40);
		period(1, 1);
		$display("clock test done");
	endtask : t_clock

	task t_trigger;
		cpu_i_mask <= 1'b0;
		wr(`OFS_MISC, 8'h50);
		rd(`OFS_MISC, d);
		check("trigger unmasked", d, 8'h10);
		cpu_i_mask <= 1'b1;
		wr(`OFS_MISC, 8'h70);
		rd(`OFS_MISC, d);
		check("trigger masked", d, 8'h70);
		$display("trigger test done");
	endtask : t_trigger

	task t_irq;
		wr(`OFS_MISC, 8'h30);
		irq_level_n <= 1'b0;
		await(2, 1'b1, 5);
		wr(`OFS_MISC, 8'h50);
		step();
		check("option change clears", irq_request, 1'b0);
		irq_level_n <= 1'b1;
		await(2, 1'b1, 5);
		irq_ack <= 1'b1;
		step();
		irq_ack <= 1'b0;
		step();
		check("ack clears", irq_request, 1'b0);
		wr(`OFS_MISC, 8'h70);
		irq_level_n <= 1'b0;
		await(2, 1'b1, 5);
		wr(`OFS_MISC, 8'h10);
		await(2, 1'b1, 3);
		wr(`OFS_MISC, 8'h00);
		step();
		check("gate off", irq_request, 1'b0);
		rd(`OFS_STATUS, d);
		check("status pend", {d[7:2], d[0]}, 7'h02);
		irq_level_n <= 1'b1;
		$display("irq test done");
	endtask : t_irq

	task t_wdog;
		int n;
		n = 0;
		wr(`OFS_MISC, 8'h12);
		@(posedge clk_sys);
		wdog <= 1'b1;
		@(posedge clk_sys);
		wdog <= 1'b0;
		#1;
		await(3, 1'b1, 3);
		while (reset_pin_oe === 1'b1 && n < 40) begin
			n++;
			step();
		end
		check("drive length", n, DRV);
		rd(`OFS_MISC, d);
		check("misc after pin", d, 8'h10);
		wr(`OFS_DIR_A, 8'hff);
		check("port A oe", port_oe, 24'h0000ff);
		hold_reset <= 1'b1;
		step();
		step();
		hold_reset <= 1'b0;
		check("port_oe held", port_oe, 24'h000000);
		$display("reset pin test done");
	endtask : t_wdog

	task t_ports;
		logic prev;
		wr(`OFS_DIR_C, 8'hff);
		wr(`OFS_PORT_C, 8'ha5);
		step();
		check("port C oe", port_oe[23:16], 8'hff);
		check("port C out", port_out[23:16], 8'ha5);
		rd(`OFS_PORT_A, d);
		check("port A in", d, 8'h3c);
		rd(`OFS_PORT_B, d);
		check("port B in", d, 8'hc3);
		rd(`OFS_PORT_C, d);
		check("port C latch", d, 8'ha5);
		rd(`OFS_DIR_C, d);
		check("dir C", d, 8'hff);
		wr(`OFS_CLK_CTRL, 8'h03);
		step();
		check("analog on", analog_select, 1'b1);
		for (int i = 0; i < 4; i++) begin
			prev = bus_clk;
			step();
			check("clock out", port_out[`PORT_C2_INDEX], prev);
		end
		rd(`OFS_PORT_D, d);
		check("port D", d, 8'h96);
		$display("port test done");
	endtask : t_ports

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		fails = 0;
		total_checks = 0;
		reset_n = 1'b0;
		req = '0;
		cpu_i_mask = 1'b1;
		stop_entry = 1'b0;
		irq_ack = 1'b0;
		wdog = 1'b0;
		irq_level_n = 1'b1;
		hold_reset = 1'b0;
		port_in = 24'h5a_c3_3c;
		an_in = 8'h96;
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		step();
		t_reset();
		t_clock();
		t_trigger();
		t_irq();
		t_wdog();
		t_ports();
		report_and_stop();
	end
endmodule : slow_clock_and_misc_control_test
